// ---- src/eci_ctrl_regs.sv ----
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
// Summary of operation
// - run command enables traffic, clears halt
// - init plus run: fetch first, then run
// - run set by one, cleared by halt
// - init launches init block fetch, clears halt
// - init bit stays set after fetch
// - init set by one, cleared by halt
// - low address write also updates shadow
// - address regs only reachable while halted
// - high address in low byte, top zero
// - high address write also updates shadow
// - babble, missed, memory masks block summary
// - rx, tx, init-done masks block summary
// - masks reset clear, kept through halt
// - reserved mask bits read as zero
// - mask bit 4 disables two-part deferral
// - mask bit 3 selects modified backoff
// - auto-pad pads frames to 64 bytes
// - auto-pad forces fcs append over pad
// - auto-strip removes pad and fcs
// - pad and strip enables clear on reset
// - halt stops all, wins, set by reset
// - summary flag drives irq when enabled
module eci_ctrl_regs
	import eci_pkg::*;
(
	// clock and reset
	input  wire logic          CLK_I,
	input  wire logic          RST_N_I,
	// register port
	input  wire eci_bus_req_t  REG_REQ_I,
	output logic [DATA_W-1:0]  REG_RDATA_O,
	// engine events
	input  wire eci_evt_t      EVT_I,
	// init block fetch
	output logic               INIT_FETCH_REQ_O,
	output logic [23:0]        INIT_FETCH_ADDR_O,
	input  wire logic          INIT_FETCH_DONE_I,
	// operating state
	output logic               HALTED_O,
	output logic               TX_ON_O,
	output logic               RX_ON_O,
	output logic               IRQ_O,
	// transmitter controls
	output logic               DEFER2_DISABLE_O,
	output logic               MOD_BACKOFF_O,
	output logic               TX_AUTO_PAD_O,
	input  wire logic          TX_FCS_DISABLE_I,
	input  wire logic [10:0]   TX_FRAME_LEN_I,
	output logic               TX_FCS_APPEND_O,
	output logic [5:0]         TX_PAD_BYTES_O,
	// receiver controls
	output logic               RX_AUTO_STRIP_O
);

	eci_core_t              core_reg;
	eci_core_t              core_next;

	logic                   ctrl_wr;
	logic                   halt_wr;
	logic                   lo_wr;
	logic                   hi_wr;
	logic                   fetch_done;
	logic [STAT_N-1:0]      stat_set;
	logic [STAT_N-1:0]      stat_q;
	logic [15:0]            status_vec;
	logic [INIT_BLOCK_ADDRESS_LO_W-1:0]   init_block_address_lo;
	logic [INIT_BLOCK_ADDRESS_LO_W-1:0]   shd_lo;
	logic [INIT_BLOCK_ADDRESS_HI_W-1:0]   init_block_address_hi;
	logic [INIT_BLOCK_ADDRESS_HI_W-1:0]   shd_hi;
	logic [10:0]            body_min;
	logic [10:0]            pad_full;

	// bus decode
	assign ctrl_wr = REG_REQ_I.wr && (REG_REQ_I.addr == OFS_CTRL);
	assign halt_wr = ctrl_wr && REG_REQ_I.wdata[CTL_HALT];

	// address registers only take writes while halted
	assign lo_wr = REG_REQ_I.wr && core_reg.halt
		&& (REG_REQ_I.addr == OFS_INIT_BLOCK_ADDRESS_LO);
	assign hi_wr = REG_REQ_I.wr && core_reg.halt
		&& (REG_REQ_I.addr == OFS_INIT_BLOCK_ADDRESS_HI);

	assign fetch_done = INIT_FETCH_DONE_I
		&& (core_reg.run_state == ST_FETCH);

	// status event vector, index order follows STAT_POS
	assign stat_set = {EVT_I.babble,
		EVT_I.missed,
		EVT_I.mem_err,
		EVT_I.rx_done,
		EVT_I.tx_done,
		fetch_done};

	// sticky status bits, write one to clear
	genvar gi;
	generate
		for (gi = 0; gi < STAT_N; gi++) begin : g_stat
			eci_sticky_bit u_stat (
				.clk_i   (CLK_I),
				.rst_n_i (RST_N_I),
				.set_i   (stat_set[gi]),
				.clr_i   (ctrl_wr
					&& REG_REQ_I.wdata[STAT_POS[gi]]),
				.halt_i  (halt_wr),
				.q_o     (stat_q[gi])
			);
		end
	endgenerate

	always_comb begin
		status_vec = '0;
		for (int i = 0; i < STAT_N; i++) begin
			status_vec[STAT_POS[i]] = stat_q[i];
		end
	end

	// low address: bit 0 kept as written, software keeps it zero
	eci_shadow_reg #(
		.W (INIT_BLOCK_ADDRESS_LO_W)
	) u_init_block_address_lo (
		.clk_i    (CLK_I),
		.wr_i     (lo_wr),
		.wdata_i  (REG_REQ_I.wdata),
		.q_o      (init_block_address_lo),
		.shadow_o (shd_lo)
	);

	// high address: only the low byte is stored
	eci_shadow_reg #(
		.W (INIT_BLOCK_ADDRESS_HI_W)
	) u_init_block_address_hi (
		.clk_i    (CLK_I),
		.wr_i     (hi_wr),
		.wdata_i  (REG_REQ_I.wdata[INIT_BLOCK_ADDRESS_HI_W-1:0]),
		.q_o      (init_block_address_hi),
		.shadow_o (shd_hi)
	);

	// padding: body bytes needed before fcs to reach minimum frame
	assign body_min = MIN_FRAME_BYTES - FCS_BYTES;
	assign pad_full = body_min - TX_FRAME_LEN_I;

	always_comb begin
		core_next       = core_reg;
		core_next.rdata = '0;

		// fetch completion first, so a same-cycle write can override
		// init bit is deliberately left untouched here
		if (fetch_done) begin
			if (core_reg.run_command) begin
				core_next.run_state = ST_RUN;
			end else begin
				core_next.run_state = ST_READY;
			end
		end

		if (ctrl_wr) begin
			if (halt_wr) begin
				// halt overrides run and init in the same write
				core_next.halt        = 1'b1;
				core_next.run_command = 1'b0;
				core_next.init        = 1'b0;
				core_next.irq_enable  = 1'b0;
				core_next.run_state   = ST_HALT;
			end else begin
				core_next.irq_enable =
					REG_REQ_I.wdata[CTL_IRQ_EN];
				// zero writes to run and init are ignored
				if (REG_REQ_I.wdata[CTL_RUN]) begin
					core_next.run_command = 1'b1;
					core_next.halt        = 1'b0;
				end
				if (REG_REQ_I.wdata[CTL_INIT]) begin
					core_next.init      = 1'b1;
					core_next.halt      = 1'b0;
					core_next.run_state = ST_FETCH;
				end else if (REG_REQ_I.wdata[CTL_RUN]
					&& (core_next.run_state == ST_HALT
					|| core_next.run_state == ST_READY)) begin
					core_next.run_state = ST_RUN;
				end
			end
		end

		// masks and feature bits are untouched by halt
		if (REG_REQ_I.wr && REG_REQ_I.addr == OFS_MASK) begin
			core_next.mask =
				REG_REQ_I.wdata & MASK_WR_BITS;
		end
		if (REG_REQ_I.wr && REG_REQ_I.addr == OFS_FEAT) begin
			core_next.tx_auto_pad_enable =
				REG_REQ_I.wdata[FEAT_PAD];
			core_next.rx_auto_strip_enable =
				REG_REQ_I.wdata[FEAT_STRIP];
		end

		// summary flag from unmasked causes; statuses empty on halt
		core_next.summary_irq_flag =
			|(status_vec & ~core_reg.mask);
		core_next.irq = core_next.summary_irq_flag
			&& core_next.irq_enable;

		// auto-pad forces the fcs and ignores the per-frame disable
		core_next.fcs_append = core_reg.tx_auto_pad_enable
			|| !TX_FCS_DISABLE_I;
		if (core_reg.tx_auto_pad_enable
			&& TX_FRAME_LEN_I < body_min) begin
			core_next.pad_bytes = pad_full[5:0];
		end else begin
			core_next.pad_bytes = '0;
		end

		// read mux, data stand in the following cycle only
		if (REG_REQ_I.rd) begin
			unique case (REG_REQ_I.addr)
				OFS_CTRL: begin
					core_next.rdata = status_vec;
					core_next.rdata[CTL_SUMM] =
						core_reg.summary_irq_flag;
					core_next.rdata[CTL_IRQ_EN] =
						core_reg.irq_enable;
					core_next.rdata[CTL_RX_ON] =
						(core_reg.run_state == ST_RUN);
					core_next.rdata[CTL_TX_ON] =
						(core_reg.run_state == ST_RUN);
					core_next.rdata[CTL_HALT] = core_reg.halt;
					core_next.rdata[CTL_RUN] =
						core_reg.run_command;
					core_next.rdata[CTL_INIT] = core_reg.init;
				end
				OFS_INIT_BLOCK_ADDRESS_LO: begin
					if (core_reg.halt) begin
						core_next.rdata = init_block_address_lo;
					end
				end
				OFS_INIT_BLOCK_ADDRESS_HI: begin
					// upper byte always reads zero
					if (core_reg.halt) begin
						core_next.rdata[INIT_BLOCK_ADDRESS_HI_W-1:0] =
							init_block_address_hi;
					end
				end
				OFS_MASK: begin
					// reserved bits are never stored, so read zero
					core_next.rdata = core_reg.mask;
				end
				OFS_FEAT: begin
					core_next.rdata[FEAT_PAD] =
						core_reg.tx_auto_pad_enable;
					core_next.rdata[FEAT_STRIP] =
						core_reg.rx_auto_strip_enable;
				end
				OFS_SHD_LO: begin
					core_next.rdata = shd_lo;
				end
				OFS_SHD_HI: begin
					core_next.rdata[INIT_BLOCK_ADDRESS_HI_W-1:0] = shd_hi;
				end
				default: begin
					core_next.rdata = '0;
				end
			endcase
		end
	end

	// reset: halted, all enables and masks cleared
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			core_reg                      <= '0;
			core_reg.run_state            <= ST_HALT;
			core_reg.halt                 <= 1'b1;
			core_reg.run_command          <= 1'b0;
			core_reg.init                 <= 1'b0;
			core_reg.mask                 <= MASK_RST;
			core_reg.tx_auto_pad_enable   <= 1'b0;
			core_reg.rx_auto_strip_enable <= 1'b0;
		end else begin
			core_reg <= core_next;
		end
	end

	// fetch address comes from the shadows, not the live copies
	assign INIT_FETCH_REQ_O  = (core_reg.run_state == ST_FETCH);
	assign INIT_FETCH_ADDR_O = {shd_hi, shd_lo};

	// init bit is left set once the fetch completes
	assign HALTED_O = core_reg.halt;
	assign TX_ON_O  = (core_reg.run_state == ST_RUN);
	assign RX_ON_O  = (core_reg.run_state == ST_RUN);
	assign IRQ_O    = core_reg.irq;

	assign DEFER2_DISABLE_O = core_reg.mask[MASK_DEFER2];
	assign MOD_BACKOFF_O    = core_reg.mask[MASK_BACKOFF];
	assign TX_AUTO_PAD_O    = core_reg.tx_auto_pad_enable;
	assign TX_FCS_APPEND_O  = core_reg.fcs_append;
	assign TX_PAD_BYTES_O   = core_reg.pad_bytes;
	assign RX_AUTO_STRIP_O  = core_reg.rx_auto_strip_enable;
	assign REG_RDATA_O      = core_reg.rdata;

endmodule

// ---- src/eci_pkg.sv ----
package eci_pkg;

	// register byte offsets
	localparam logic [7:0] OFS_CTRL    = 8'h00;
	localparam logic [7:0] OFS_INIT_BLOCK_ADDRESS_LO = 8'h04;
	localparam logic [7:0] OFS_INIT_BLOCK_ADDRESS_HI = 8'h08;
	localparam logic [7:0] OFS_MASK    = 8'h0C;
	localparam logic [7:0] OFS_FEAT    = 8'h10;
	localparam logic [7:0] OFS_SHD_LO  = 8'h40;
	localparam logic [7:0] OFS_SHD_HI  = 8'h44;

	localparam int unsigned DATA_W = 16;
	localparam int unsigned ADDR_W = 8;

	// control register fields
	localparam int unsigned CTL_INIT   = 0;
	localparam int unsigned CTL_RUN    = 1;
	localparam int unsigned CTL_HALT   = 2;
	localparam int unsigned CTL_TX_ON  = 4;
	localparam int unsigned CTL_RX_ON  = 5;
	localparam int unsigned CTL_IRQ_EN = 6;
	localparam int unsigned CTL_SUMM   = 7;

	// sticky status bits, same positions as their mask bits
	localparam int unsigned STAT_N = 6;
	localparam int unsigned STAT_POS [STAT_N] = '{8, 9, 10, 11, 12, 14};

	// mask register: writable bits, deferral and backoff fields
	localparam logic [15:0] MASK_WR_BITS  = 16'h5F18;
	localparam int unsigned MASK_DEFER2   = 4;
	localparam int unsigned MASK_BACKOFF  = 3;
	localparam logic [15:0] MASK_RST      = 16'h0000;

	// feature register fields
	localparam int unsigned FEAT_PAD   = 11;
	localparam int unsigned FEAT_STRIP = 10;

	// padding arithmetic, in bytes
	localparam logic [10:0] MIN_FRAME_BYTES = 11'h040;
	localparam logic [10:0] FCS_BYTES       = 11'h004;

	localparam int unsigned INIT_BLOCK_ADDRESS_LO_W = 16;
	localparam int unsigned INIT_BLOCK_ADDRESS_HI_W = 8;

	typedef enum logic [1:0] {
		ST_HALT  = 2'h0,
		ST_FETCH = 2'h1,
		ST_RUN   = 2'h3,
		ST_READY = 2'h2
	} eci_run_t;

	typedef struct packed {
		logic                wr;
		logic                rd;
		logic [ADDR_W-1:0]   addr;
		logic [DATA_W-1:0]   wdata;
	} eci_bus_req_t;

	typedef struct packed {
		logic babble;
		logic missed;
		logic mem_err;
		logic rx_done;
		logic tx_done;
	} eci_evt_t;

	typedef struct packed {
		logic q;
	} eci_sticky_t;

	typedef struct packed {
		eci_run_t            run_state;
		logic                halt;
		logic                run_command;
		logic                init;
		logic                irq_enable;
		logic                summary_irq_flag;
		logic                irq;
		logic [15:0]         mask;
		logic                tx_auto_pad_enable;
		logic                rx_auto_strip_enable;
		logic [DATA_W-1:0]   rdata;
		logic                fcs_append;
		logic [5:0]          pad_bytes;
	} eci_core_t;

endpackage

// ---- src/eci_sticky_bit.sv ----
`timescale 1ns/1ps
module eci_sticky_bit
	import eci_pkg::*;
(
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	// controls
	input  wire logic set_i,
	input  wire logic clr_i,
	input  wire logic halt_i,
	// state
	output logic      q_o
);

	eci_sticky_t st_reg;
	eci_sticky_t st_next;

	// an event in the clearing cycle survives; halt always empties it
	always_comb begin
		st_next = st_reg;
		if (halt_i) begin
			st_next.q = 1'b0;
		end else if (set_i) begin
			st_next.q = 1'b1;
		end else if (clr_i) begin
			st_next.q = 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign q_o = st_reg.q;

endmodule

// ---- src/eci_shadow_reg.sv ----
`timescale 1ns/1ps
module eci_shadow_reg
	import eci_pkg::*;
#(
	parameter int unsigned W = 16
) (
	// clock
	input  wire logic         clk_i,
	// write side
	input  wire logic         wr_i,
	input  wire logic [W-1:0] wdata_i,
	// contents
	output logic [W-1:0]      q_o,
	output logic [W-1:0]      shadow_o
);

	typedef struct packed {
		logic [W-1:0] live;
		logic [W-1:0] shadow;
	} eci_shadow_t;

	eci_shadow_t st_reg;
	eci_shadow_t st_next;

	always_comb begin
		st_next = st_reg;
		if (wr_i) begin
			st_next.live   = wdata_i;
			st_next.shadow = wdata_i;
		end
	end

	// no reset: contents must survive a hardware reset
	always_ff @(posedge clk_i) begin
		st_reg <= st_next;
	end

	assign q_o      = st_reg.live;
	assign shadow_o = st_reg.shadow;

endmodule

// ---- verif/eci_ctrl_regs_sva.sv ----
`timescale 1ns/1ps
module eci_ctrl_regs_sva
	import eci_pkg::*;
(
	// clock and reset
	input wire logic         CLK_I,
	input wire logic         RST_N_I,
	// register port
	input wire eci_bus_req_t REG_REQ_I,
	// fetch and state
	input wire logic         INIT_FETCH_REQ_O,
	input wire logic         INIT_FETCH_DONE_I,
	input wire logic         HALTED_O,
	input wire logic         TX_ON_O,
	input wire logic         IRQ_O,
	// transmit and receive controls
	input wire logic         DEFER2_DISABLE_O,
	input wire logic         MOD_BACKOFF_O,
	input wire logic         TX_AUTO_PAD_O,
	input wire logic [10:0]  TX_FRAME_LEN_I,
	input wire logic         TX_FCS_APPEND_O,
	input wire logic [5:0]   TX_PAD_BYTES_O,
	input wire logic         RX_AUTO_STRIP_O
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RST_N_I);
	logic [15:0] wd;
	logic        wc;
	logic        wm;
	assign wd = REG_REQ_I.wdata;
	assign wc = REG_REQ_I.wr && REG_REQ_I.addr == OFS_CTRL;
	assign wm = REG_REQ_I.wr && REG_REQ_I.addr == OFS_MASK;
	// state register may add one cycle before traffic turns on
	property p_run;
		wc && wd[2:0] == 3'h2 && !INIT_FETCH_REQ_O
		|=> !HALTED_O ##[0:1] TX_ON_O;
	endproperty
	a_run: assert property (p_run) else $error("run ignored");
	property p_init;
		wc && wd[CTL_INIT] && !wd[CTL_HALT] |=> INIT_FETCH_REQ_O && !HALTED_O;
	endproperty
	a_init: assert property (p_init) else $error("init ignored");
	property p_halt;
		wc && wd[CTL_HALT] |=> HALTED_O && !TX_ON_O && !INIT_FETCH_REQ_O;
	endproperty
	a_halt: assert property (p_halt) else $error("halt lost");
	property p_mask;
		wm |=> DEFER2_DISABLE_O == $past(wd[MASK_DEFER2])
		&& MOD_BACKOFF_O == $past(wd[MASK_BACKOFF]);
	endproperty
	a_mask: assert property (p_mask) else $error("mask out");
	property p_keep;
		wc && wd[CTL_HALT] |=> $stable(DEFER2_DISABLE_O) && $stable(MOD_BACKOFF_O);
	endproperty
	a_keep: assert property (p_keep) else $error("mask lost");
	property p_feat;
		REG_REQ_I.wr && REG_REQ_I.addr == OFS_FEAT
		|=> TX_AUTO_PAD_O == $past(wd[FEAT_PAD])
		&& RX_AUTO_STRIP_O == $past(wd[FEAT_STRIP]);
	endproperty
	a_feat: assert property (p_feat) else $error("feature out");
	property p_fcs;
		TX_AUTO_PAD_O |=> TX_FCS_APPEND_O;
	endproperty
	a_fcs: assert property (p_fcs) else $error("fcs dropped");
	property p_pad;
		TX_AUTO_PAD_O && TX_FRAME_LEN_I < 11'h03C
		|=> TX_PAD_BYTES_O == 6'(11'h03C - $past(TX_FRAME_LEN_I));
	endproperty
	a_pad: assert property (p_pad) else $error("pad count");
	c_fetch: cover property (INIT_FETCH_REQ_O && INIT_FETCH_DONE_I);
	c_irq: cover property ($rose(IRQ_O));
	c_pad: cover property (TX_PAD_BYTES_O != 6'h00);
endmodule
bind eci_ctrl_regs eci_ctrl_regs_sva eci_ctrl_regs_sva_i (.CLK_I, .RST_N_I,
	.REG_REQ_I, .INIT_FETCH_REQ_O, .INIT_FETCH_DONE_I, .HALTED_O, .TX_ON_O,
	.IRQ_O, .DEFER2_DISABLE_O, .MOD_BACKOFF_O, .TX_AUTO_PAD_O,
	.TX_FRAME_LEN_I, .TX_FCS_APPEND_O, .TX_PAD_BYTES_O, .RX_AUTO_STRIP_O);

// ---- verif/eci_fetch_mem.sv ----
`timescale 1ns/1ps
module eci_fetch_mem (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	// fetch handshake
	input  wire logic       req_i,
	input  wire logic [3:0] delay_i,
	output logic            done_o
);
	// one done pulse per request, delay_i + 1 cycles after req_i rises
	logic       go;
	logic [3:0] cnt_reg;
	assign go = req_i && !done_o;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_reg <= 4'h0;
			done_o  <= 1'b0;
		end else begin
			done_o  <= go && cnt_reg == delay_i;
			cnt_reg <= (go && cnt_reg != delay_i) ? cnt_reg + 4'h1 : 4'h0;
		end
	end
endmodule

// ---- verif/eci_ctrl_regs_tb_top.sv ----
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin \
	compares++; \
	if ((gt) !== (ex)) begin \
		fail_count++; \
		$display("ERROR %s expected %h seen %h", nm, ex, gt); \
	end \
end
module eci_ctrl_regs_tb_top
	import eci_pkg::*;
;
	logic         CLK_I, RST_N_I, INIT_FETCH_DONE_I, TX_FCS_DISABLE_I;
	logic         INIT_FETCH_REQ_O, HALTED_O, TX_ON_O, RX_ON_O, IRQ_O;
	logic         DEFER2_DISABLE_O, MOD_BACKOFF_O, TX_AUTO_PAD_O;
	logic         TX_FCS_APPEND_O, RX_AUTO_STRIP_O;
	eci_bus_req_t REG_REQ_I;
	eci_evt_t     EVT_I;
	logic [10:0]  TX_FRAME_LEN_I;
	logic [15:0]  REG_RDATA_O, lo, r;
	logic [23:0]  INIT_FETCH_ADDR_O;
	logic [7:0]   hi;
	logic [5:0]   TX_PAD_BYTES_O;
	logic [3:0]   dly;
	int           fail_count, compares, cyc, i, p;
	eci_ctrl_regs eci_ctrl_regs_i (.CLK_I, .RST_N_I, .REG_REQ_I, .REG_RDATA_O,
		.EVT_I, .INIT_FETCH_REQ_O, .INIT_FETCH_ADDR_O, .INIT_FETCH_DONE_I,
		.HALTED_O, .TX_ON_O, .RX_ON_O, .IRQ_O, .DEFER2_DISABLE_O,
		.MOD_BACKOFF_O, .TX_AUTO_PAD_O, .TX_FCS_DISABLE_I, .TX_FRAME_LEN_I,
		.TX_FCS_APPEND_O, .TX_PAD_BYTES_O, .RX_AUTO_STRIP_O);
	eci_fetch_mem eci_fetch_mem_i (.clk_i(CLK_I), .rst_n_i(RST_N_I),
		.req_i(INIT_FETCH_REQ_O), .delay_i(dly), .done_o(INIT_FETCH_DONE_I));
	initial begin
		CLK_I = 1'b0;
		forever #20 CLK_I = ~CLK_I;
	end
	task automatic wrap_up();
		if (fail_count == 0 && compares > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	always @(posedge CLK_I) begin
		cyc++;
		if (cyc == 5000) begin
			fail_count++;
			wrap_up();
		end
	end
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge CLK_I);
		REG_REQ_I <= {1'b1, 1'b0, a, d};
		@(posedge CLK_I);
		REG_REQ_I <= '0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [15:0] e, string nm);
		@(posedge CLK_I);
		REG_REQ_I <= {1'b0, 1'b1, a, 16'h0000};
		@(posedge CLK_I);
		REG_REQ_I <= '0;
		#1 `CHK(nm, e, REG_RDATA_O)
	endtask
	// irq judged only once status and summary have both settled
	task automatic evt(input int k, input logic e);
		@(posedge CLK_I);
		EVT_I <= eci_evt_t'(5'h01 << k);
		@(posedge CLK_I);
		EVT_I <= '0;
		repeat (3) @(posedge CLK_I);
		#1 `CHK("irq", e, IRQ_O)
	endtask
	function automatic logic [5:0] pad_exp(input int on, input logic [10:0] n);
		return (on != 0 && n < 11'h03C) ? 6'(11'h03C - n) : 6'h00;
	endfunction
	initial begin
		void'($urandom(32));
		RST_N_I = 1'b0;
		REG_REQ_I = '0;
		EVT_I = '0;
		TX_FCS_DISABLE_I = 1'b0;
		TX_FRAME_LEN_I = '0;
		dly = 4'($urandom_range(2, 12));
		repeat (12) @(posedge CLK_I);
		RST_N_I <= 1'b1;
		rdc(OFS_CTRL, 16'h0004, "ctrl");
		rdc(OFS_MASK, 16'h0000, "mask");
		rdc(OFS_FEAT, 16'h0000, "feature");
		lo = 16'($urandom) & 16'hFFFE;
		hi = 8'($urandom);
		wr(OFS_INIT_BLOCK_ADDRESS_LO, lo);
		wr(OFS_INIT_BLOCK_ADDRESS_HI, {8'h00, hi});
		rdc(OFS_INIT_BLOCK_ADDRESS_LO, lo, "addr low");
		rdc(OFS_SHD_LO, lo, "shadow low");
		rdc(OFS_INIT_BLOCK_ADDRESS_HI, {8'h00, hi}, "addr high");
		rdc(OFS_SHD_HI, {8'h00, hi}, "shadow high");
		`CHK("fetch addr", {hi, lo}, INIT_FETCH_ADDR_O)
		r = 16'($urandom);
		wr(OFS_MASK, r);
		rdc(OFS_MASK, r & MASK_WR_BITS, "mask");
		`CHK("defer2", r[MASK_DEFER2], DEFER2_DISABLE_O)
		`CHK("backoff", r[MASK_BACKOFF], MOD_BACKOFF_O)
		for (p = 0; p < 2; p++) begin
			wr(OFS_FEAT, p[0] ? 16'h0C00 : 16'h0000);
			for (i = 0; i < 12; i++) begin
				@(posedge CLK_I);
				TX_FRAME_LEN_I <= (i < 3) ? 11'(58 + i) : 11'($urandom_range(0, 90));
				TX_FCS_DISABLE_I <= i[0];
				@(posedge CLK_I);
				#1 `CHK("pad", pad_exp(p, TX_FRAME_LEN_I), TX_PAD_BYTES_O)
				`CHK("fcs", p[0] | ~i[0], TX_FCS_APPEND_O)
			end
			`CHK("strip", p[0], RX_AUTO_STRIP_O)
		end
		wr(OFS_MASK, 16'h0000);
		wr(OFS_CTRL, 16'h0043);
		#1 `CHK("fetch", 1'b1, INIT_FETCH_REQ_O)
		`CHK("tx early", 1'b0, TX_ON_O)
		for (i = 0; i < 40 && TX_ON_O !== 1'b1; i++) #40;
		#80 `CHK("rx on", 1'b1, RX_ON_O)
		`CHK("irq init", 1'b1, IRQ_O)
		rdc(OFS_CTRL, 16'h01F3, "ctrl run");
		wr(OFS_INIT_BLOCK_ADDRESS_LO, ~lo);
		rdc(OFS_INIT_BLOCK_ADDRESS_LO, 16'h0000, "addr hidden");
		wr(OFS_CTRL, 16'h0140);
		rdc(OFS_CTRL, 16'h0073, "ctrl kept");
		for (i = 0; i < 5; i++) begin
			p = STAT_POS[i + 1];
			wr(OFS_MASK, 16'h0001 << p);
			evt(i, 1'b0);
			wr(OFS_CTRL, 16'h0040 | (16'h0001 << p));
			wr(OFS_MASK, 16'h0000);
			evt(i, 1'b1);
			wr(OFS_CTRL, 16'h0040 | (16'h0001 << p));
		end
		wr(OFS_MASK, r);
		wr(OFS_CTRL, 16'h0007);
		#1 `CHK("halt", 1'b1, HALTED_O)
		rdc(OFS_CTRL, 16'h0004, "ctrl halt");
		rdc(OFS_MASK, r & MASK_WR_BITS, "mask kept");
		rdc(OFS_INIT_BLOCK_ADDRESS_LO, lo, "addr kept");
		rdc(8'h20, 16'h0000, "unmapped");
		wr(OFS_CTRL, 16'h0002);
		#41 RST_N_I = 1'b0;
		#80 RST_N_I = 1'b1;
		rdc(OFS_FEAT, 16'h0000, "feature rst");
		rdc(OFS_MASK, 16'h0000, "mask rst");
		rdc(OFS_INIT_BLOCK_ADDRESS_LO, lo, "addr rst");
		rdc(OFS_CTRL, 16'h0004, "ctrl rst");
		wrap_up();
	end
endmodule
